// >>> hw/uart_ier_regs.svh
// register addresses, field positions, reset values for the serial irq block
`ifndef UART_IER_REGS_SVH
`define UART_IER_REGS_SVH

// byte addresses on the peripheral bus
`define ADDR_IRQ_ENABLE      32'hE001_0004
`define ADDR_LINE_STATUS     32'hE001_0014
`define ADDR_MODEM_STATUS    32'hE001_0018
`define ADDR_PORT_CONTROL    32'hE001_0020
`define ADDR_IRQ_STATUS      32'hE001_0030
`define ADDR_IRQ_CLEAR       32'hE001_0034

// enable / status / clear bit positions (one layout for all three)
`define BIT_RX_DATA          0
`define BIT_TX_EMPTY         1
`define BIT_LINE_STATUS      2
`define BIT_MODEM_STATUS     3
`define BIT_CTS_CHANGE       7
`define BIT_AUTOBAUD_TIMEOUT 8
`define BIT_AUTOBAUD_DONE    9

// writable enable bits; 6:4 and 31:10 are kept at zero
`define IRQ_WRITE_MASK       32'h0000_038F
`define IRQ_ENABLE_RESET     10'h000
`define IRQ_STATUS_RESET     10'h000

// port control fields
`define BIT_DIVISOR_ACCESS   0
`define BIT_AUTO_CTS         1
`define PORT_CONTROL_MASK    32'h0000_0003

// line status fields
`define BIT_LSR_DATA_READY   0
`define LSR_ERR_LO           1
`define LSR_ERR_HI           4
`define BIT_LSR_TX_EMPTY     5

// modem status fields
`define MSR_DELTA_HI         3
`define BIT_MSR_DELTA_CTS    0
`define BIT_MSR_CTS_LEVEL    4

`endif

// >>> hw/uart_ier_pkg.sv
// types for the serial irq enable block
`default_nettype none
package uart_ier_pkg;

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } sync_state_t;

    typedef struct packed {
        logic [9:0]  irq_enable;
        logic [9:0]  irq_status;
        logic        divisor_access;
        logic        auto_cts;
        logic [3:0]  line_err;
        logic [3:0]  modem_delta;
        logic        rx_ready;
        logic        tx_empty;
        logic        tx_empty_prev;
        logic        rx_ready_prev;
        logic        cts_level;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
        logic        irq;
    } port_state_t;

endpackage
`default_nettype wire

// >>> hw/pin_sync.sv
// three-stage synchroniser with change detect for one pin
`default_nettype none
module pin_sync (
    // clocking
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic clk_en,
    // pin side
    input  wire logic pin_in,
    // clock side
    output logic      level,
    output logic      changed
);
    uart_ier_pkg::sync_state_t st_ff;
    uart_ier_pkg::sync_state_t nxt_st;

    always_comb begin
        nxt_st    = st_ff;
        nxt_st.s1 = pin_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    // s1 only feeds s2; change is decided between s2 and s3
    assign level   = st_ff.s3;
    assign changed = st_ff.s2 ^ st_ff.s3;
endmodule
`default_nettype wire

// >>> hw/uart_interrupt_enable.sv
// serial port interrupt enable register with source gating and apb slave
//
// Contract
// (RULE1) bit 0 gates received data and character time-out together.
// (RULE2) bit 1 gates transmit holding empty; line status bit 5 shows it.
// (RULE3) bit 2 gates line status interrupt; errors shown in line status 4:1.
// (RULE4) bit 3 gates modem interrupt; change flags shown in modem status 3:0.
// (RULE5) software writes zeros to bits 6:4 and 31:10; reads are undefined.
// (RULE6) auto flow control on: clear-to-send change needs bits 3 and 7.
// (RULE7) auto flow control off: clear-to-send change needs bit 3 only.
// (RULE8) bit 8 gates the auto-baud time-out interrupt.
// (RULE9) bit 9 gates the auto-baud completion interrupt.
// (RULE10) answers only while divisor access bit is zero; enables reset to zero.
// (RULE11) irq high while any pending source meets its set enable bit.
//
// Register access over APB was chosen for this implementation.
`include "uart_ier_regs.svh"
`default_nettype none
module uart_interrupt_enable (
    // clock, reset, enable
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // receive path sources
    input  wire logic        receive_data_available,
    input  wire logic        char_timeout,
    input  wire logic [3:0]  line_error,
    // transmit path source
    input  wire logic        transmit_holding_empty,
    // modem sources
    input  wire logic        clear_to_send_input,
    input  wire logic [2:0]  modem_change,
    // auto-baud sources
    input  wire logic        autobaud_timeout,
    input  wire logic        autobaud_done,
    // interrupt and mode outputs
    output logic             irq,
    output logic             divisor_latch_access_bit,
    output logic             auto_cts_enable
);
    uart_ier_pkg::port_state_t st_ff;
    uart_ier_pkg::port_state_t nxt_st;

    logic cts_level;
    logic cts_changed;

    pin_sync u_cts_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .clk_en  (clk_en),
        .pin_in  (clear_to_send_input),
        .level   (cts_level),
        .changed (cts_changed)
    );

    // decoded bus phases
    logic        setup_phase;
    logic        access_done;
    logic        wr_done;
    logic        rd_setup;
    logic        hit_enable;
    logic        hit_line;
    logic        hit_modem;
    logic        hit_ctrl;
    logic        hit_status;
    logic        hit_clear;
    logic        mapped;
    logic        writable;
    logic [31:0] rd_word;
    logic [9:0]  ev_set;
    logic [9:0]  ev_clr;
    logic [9:0]  eff_enable;
    logic [3:0]  err_next;
    logic [3:0]  delta_next;
    logic [31:0] lsr_word;
    logic [31:0] msr_word;

    always_comb begin
        setup_phase = psel && !penable;
        access_done = psel && penable && st_ff.pready;
        // enable register hides behind the divisor latch
        hit_enable  = (paddr == `ADDR_IRQ_ENABLE) &&
                      !st_ff.divisor_access; // [RULE10]
        hit_line    = (paddr == `ADDR_LINE_STATUS);
        hit_modem   = (paddr == `ADDR_MODEM_STATUS);
        hit_ctrl    = (paddr == `ADDR_PORT_CONTROL);
        hit_status  = (paddr == `ADDR_IRQ_STATUS);
        hit_clear   = (paddr == `ADDR_IRQ_CLEAR);
        mapped      = hit_enable || hit_line || hit_modem ||
                      hit_ctrl || hit_status || hit_clear;
        // status registers are read only, clear is write only
        writable    = hit_enable || hit_ctrl || hit_clear;
        wr_done     = access_done && pwrite && writable;
        rd_setup    = setup_phase && !pwrite;
    end

    // line status and modem status words as software sees them
    always_comb begin
        lsr_word = 32'h0000_0000;
        lsr_word[`BIT_LSR_DATA_READY] = st_ff.rx_ready;
        lsr_word[`LSR_ERR_HI:`LSR_ERR_LO] = st_ff.line_err; // [RULE3]
        // live level, visible whatever the enable says
        lsr_word[`BIT_LSR_TX_EMPTY] = st_ff.tx_empty; // [RULE2]
        msr_word = 32'h0000_0000;
        msr_word[`MSR_DELTA_HI:0] = st_ff.modem_delta; // [RULE4]
        msr_word[`BIT_MSR_CTS_LEVEL] = st_ff.cts_level;
    end

    // read mux; reserved and unused bits read as zero
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_enable) begin
            rd_word[9:0] = st_ff.irq_enable;
        end else if (hit_line) begin
            rd_word = lsr_word;
        end else if (hit_modem) begin
            rd_word = msr_word;
        end else if (hit_ctrl) begin
            rd_word[`BIT_DIVISOR_ACCESS] = st_ff.divisor_access;
            rd_word[`BIT_AUTO_CTS]       = st_ff.auto_cts;
        end else if (hit_status) begin
            rd_word[9:0] = st_ff.irq_status;
        end
    end

    // source events into sticky status bits
    always_comb begin
        ev_set = 10'h000;
        // data arriving and character time-out share one bit
        ev_set[`BIT_RX_DATA] = (receive_data_available &&
                               !st_ff.rx_ready_prev) ||
                               char_timeout; // [RULE1]
        ev_set[`BIT_TX_EMPTY] = transmit_holding_empty &&
                                !st_ff.tx_empty_prev; // [RULE2]
        ev_set[`BIT_LINE_STATUS] = |line_error; // [RULE3]
        ev_set[`BIT_MODEM_STATUS] = |modem_change; // [RULE4]
        if (cts_changed) begin
            if (st_ff.auto_cts) begin
                ev_set[`BIT_CTS_CHANGE] = 1'b1; // [RULE6]
            end else begin
                ev_set[`BIT_MODEM_STATUS] = 1'b1; // [RULE7]
            end
        end
        ev_set[`BIT_AUTOBAUD_TIMEOUT] = autobaud_timeout; // [RULE8]
        ev_set[`BIT_AUTOBAUD_DONE]    = autobaud_done; // [RULE9]
        ev_clr = 10'h000;
        if (wr_done && hit_clear) begin
            ev_clr = pwdata[9:0];
        end
    end

    // sticky error and delta flags; a read clears, a new event wins
    always_comb begin
        err_next = st_ff.line_err;
        if (access_done && !pwrite && hit_line) begin
            err_next = 4'h0;
        end
        err_next = err_next | line_error; // [RULE3]
        delta_next = st_ff.modem_delta;
        if (access_done && !pwrite && hit_modem) begin
            delta_next = 4'h0;
        end
        delta_next[`MSR_DELTA_HI:1] = delta_next[`MSR_DELTA_HI:1] |
                                      modem_change; // [RULE4]
        delta_next[`BIT_MSR_DELTA_CTS] = delta_next[`BIT_MSR_DELTA_CTS] |
                                         cts_changed; // [RULE4]
    end

    always_comb begin
        nxt_st = st_ff;
        // source tracking
        nxt_st.rx_ready      = receive_data_available;
        nxt_st.rx_ready_prev = receive_data_available;
        nxt_st.tx_empty      = transmit_holding_empty;
        nxt_st.tx_empty_prev = transmit_holding_empty;
        nxt_st.cts_level     = cts_level;
        nxt_st.line_err      = err_next;
        nxt_st.modem_delta   = delta_next;
        // set beats clear in the same cycle
        nxt_st.irq_status = (st_ff.irq_status & ~ev_clr) | ev_set;
        // register writes land on the completing access edge
        if (wr_done && hit_enable) begin
            // reserved bits are masked, never stored
            nxt_st.irq_enable = 10'(pwdata &
                                `IRQ_WRITE_MASK); // [RULE5]
        end
        if (wr_done && hit_ctrl) begin
            nxt_st.divisor_access = pwdata[`BIT_DIVISOR_ACCESS];
            nxt_st.auto_cts       = pwdata[`BIT_AUTO_CTS];
        end
        // no wait state: answer is prepared in setup, given in the first access cycle
        nxt_st.pready  = setup_phase;
        nxt_st.pslverr = 1'b0;
        if (setup_phase) begin
            nxt_st.pslverr = !mapped || (pwrite ? !writable : hit_clear);
        end
        nxt_st.prdata = 32'h0000_0000;
        if (rd_setup) begin
            nxt_st.prdata = rd_word;
        end
        // with auto cts on, cts change reaches the pin only through bits 3 and 7 together
        eff_enable = nxt_st.irq_enable;
        eff_enable[`BIT_CTS_CHANGE] = nxt_st.irq_enable[`BIT_CTS_CHANGE] &&
            nxt_st.irq_enable[`BIT_MODEM_STATUS]; // [RULE6]
        // irq follows status and enable about to be stored, no extra lag
        nxt_st.irq = |(nxt_st.irq_status & eff_enable); // [RULE11]
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff            <= '0;
            // every source starts disabled
            st_ff.irq_enable <= `IRQ_ENABLE_RESET; // [RULE10]
            st_ff.irq_status <= `IRQ_STATUS_RESET;
        end else if (clk_en) begin
            st_ff <= nxt_st;
        end
    end

    assign prdata                   = st_ff.prdata;
    assign pready                   = st_ff.pready;
    assign pslverr                  = st_ff.pslverr;
    assign irq                      = st_ff.irq;
    assign divisor_latch_access_bit = st_ff.divisor_access;
    assign auto_cts_enable          = st_ff.auto_cts;
endmodule
`default_nettype wire

// >>> tb/uart_interrupt_enable_asserts.sv
// concurrent checks on the serial irq enable block ports
`include "uart_ier_regs.svh"
`default_nettype none
module uart_interrupt_enable_asserts (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // sources
    input wire logic        receive_data_available,
    input wire logic        char_timeout,
    input wire logic [3:0]  line_error,
    input wire logic        transmit_holding_empty,
    input wire logic        clear_to_send_input,
    input wire logic [2:0]  modem_change,
    input wire logic        autobaud_timeout,
    input wire logic        autobaud_done,
    // outputs
    input wire logic        irq,
    input wire logic        divisor_latch_access_bit,
    input wire logic        auto_cts_enable
);
    logic [9:0] en_ff;
    logic       hit;

    // shadow of the enable register, kept from observed bus writes
    assign hit = psel && penable && pready && pwrite
        && paddr == `ADDR_IRQ_ENABLE && !divisor_latch_access_bit;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            en_ff <= 10'h000;
        else if (hit)
            en_ff <= pwdata[9:0] & 10'h38F;
    end

    default clocking @(posedge pclk); endclocking
    // frozen cycles answer nothing, so they are not judged
    default disable iff (!presetn || !clk_en);

    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_hidden;
        s_setup ##0 paddr == `ADDR_IRQ_ENABLE && divisor_latch_access_bit;
    endsequence
    sequence s_cts_armed;
        $changed(clear_to_send_input) && en_ff[3] &&
            (!auto_cts_enable || en_ff[7]);
    endsequence

    a_bus_answer: assert property (s_setup |=> pready)
        else $error("no bus answer after setup");
    a_hidden_reg: assert property (
        s_hidden |=> pslverr && prdata == 32'h0)
        else $error("enable register visible with divisor access");
    a_rx_gate: assert property (
        ($rose(receive_data_available) || char_timeout) && en_ff[0]
        |=> irq)
        else $error("receive event did not raise irq");
    a_tx_gate: assert property (
        $rose(transmit_holding_empty) && en_ff[1] |=> irq)
        else $error("transmit empty did not raise irq");
    a_line_gate: assert property (
        (|line_error) && en_ff[2] |=> irq)
        else $error("line error did not raise irq");
    a_modem_gate: assert property (
        (|modem_change) && en_ff[3] |=> irq)
        else $error("modem change did not raise irq");
    a_cts_gate: assert property (
        s_cts_armed |-> ##[1:8] irq)
        else $error("clear to send change did not raise irq");
    a_baud_timeout: assert property (
        autobaud_timeout && en_ff[8] |=> irq)
        else $error("auto-baud time-out did not raise irq");
    a_baud_done: assert property (
        autobaud_done && en_ff[9] |=> irq)
        else $error("auto-baud completion did not raise irq");
    a_quiet_off: assert property (en_ff == 10'h000 |-> !irq)
        else $error("irq high with nothing enabled");
endmodule
`default_nettype wire

// >>> tb/tb_uart_interrupt_enable.sv
// self-checking bench for the serial irq enable block
`include "uart_ier_regs.svh"
`default_nettype none
module tb_uart_interrupt_enable;
timeunit 1ns;
timeprecision 1ns;
    typedef struct packed {
        logic [9:0] en;
        logic [3:0] src;
        logic       aut;
        logic       exp;
        logic [9:0] st;
    } row_t;
    logic        pclk = 1'h0, presetn = 1'h0, clk_en = 1'h1;
    logic        psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
    logic        pready, pslverr, irq, div_acc, acts, err;
    logic [6:0]  ev = 7'h0;
    logic [3:0]  lerr = 4'h0;
    logic [2:0]  mchg = 3'h0;
    logic        cts = 1'h0;
    int          errors = 0, total_checks = 0, cyc = 0;
    row_t        r;
    row_t        rows [15] = '{
        {10'h001, 4'h0, 1'h0, 1'h1, 10'h001},
        {10'h38E, 4'h0, 1'h0, 1'h0, 10'h001},
        {10'h001, 4'h1, 1'h0, 1'h1, 10'h001},
        {10'h38E, 4'h1, 1'h0, 1'h0, 10'h001},
        {10'h002, 4'h2, 1'h0, 1'h1, 10'h002},
        {10'h38D, 4'h2, 1'h0, 1'h0, 10'h002},
        {10'h004, 4'h3, 1'h0, 1'h1, 10'h004},
        {10'h008, 4'h4, 1'h0, 1'h1, 10'h008},
        {10'h100, 4'h5, 1'h0, 1'h1, 10'h100},
        {10'h28F, 4'h5, 1'h0, 1'h0, 10'h100},
        {10'h200, 4'h6, 1'h0, 1'h1, 10'h200},
        {10'h008, 4'h7, 1'h0, 1'h1, 10'h008},
        {10'h080, 4'h7, 1'h0, 1'h0, 10'h008},
        {10'h088, 4'h7, 1'h1, 1'h1, 10'h080},
        {10'h008, 4'h7, 1'h1, 1'h0, 10'h080}};

    uart_interrupt_enable dut_u (
        .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .receive_data_available(ev[0]), .char_timeout(ev[1]),
        .line_error(lerr), .transmit_holding_empty(ev[2]),
        .clear_to_send_input(cts), .modem_change(mchg),
        .autobaud_timeout(ev[5]), .autobaud_done(ev[6]), .irq(irq),
        .divisor_latch_access_bit(div_acc), .auto_cts_enable(acts));

    always #25 pclk = ~pclk;

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // one apb transfer; leaves an idle edge so calls never collide
    task automatic apb(logic wr, logic [31:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task automatic fire(int s);
        @(posedge pclk);
        if (s == 7) cts <= !cts;
        else if (s == 3) lerr <= 4'h8;
        else if (s == 4) mchg <= 3'h4;
        else ev[s] <= 1'h1;
        @(posedge pclk);
        ev <= 7'h0;
        lerr <= 4'h0;
        mchg <= 3'h0;
    endtask

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            results();
        end
    end

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        apb(1'h0, `ADDR_IRQ_ENABLE, 32'h0);
        check("enable reset", rd, 32'h0);
        check("irq reset", irq, 32'h0);
        // enable register hidden while divisor access is set
        apb(1'h1, `ADDR_PORT_CONTROL, 32'h1);
        apb(1'h1, `ADDR_IRQ_ENABLE, 32'h3);
        apb(1'h0, `ADDR_IRQ_ENABLE, 32'h0);
        check("hidden err", err, 32'h1);
        check("divisor bit", div_acc, 32'h1);
        apb(1'h1, `ADDR_PORT_CONTROL, 32'h0);
        apb(1'h0, `ADDR_IRQ_ENABLE, 32'h0);
        check("hidden write", rd, 32'h0);
        $display("test divisor access done");
        // status stays visible with all enables clear
        @(posedge pclk);
        ev[2] <= 1'h1;
        lerr <= 4'hA;
        mchg <= 3'h5;
        @(posedge pclk);
        lerr <= 4'h0;
        mchg <= 3'h0;
        apb(1'h0, `ADDR_LINE_STATUS, 32'h0);
        check("line status", rd, 32'h34);
        apb(1'h0, `ADDR_MODEM_STATUS, 32'h0);
        check("modem status", rd, 32'h0A);
        check("irq masked", irq, 32'h0);
        ev[2] <= 1'h0;
        apb(1'h1, `ADDR_IRQ_CLEAR, 32'h3FF);
        $display("test status mirror done");
        foreach (rows[i]) begin
            r = rows[i];
            apb(1'h1, `ADDR_PORT_CONTROL, {30'h0, r.aut, 1'h0});
            apb(1'h1, `ADDR_IRQ_ENABLE, {22'h0, r.en});
            apb(1'h0, `ADDR_IRQ_ENABLE, 32'h0);
            check("enable", rd, {22'h0, r.en});
            check("auto cts", acts, {31'h0, r.aut});
            fire(r.src);
            repeat (6) @(posedge pclk);
            check("irq", irq, {31'h0, r.exp});
            apb(1'h0, `ADDR_IRQ_STATUS, 32'h0);
            check("status", rd, {22'h0, r.st});
            apb(1'h1, `ADDR_IRQ_CLEAR, 32'h3FF);
            @(posedge pclk);
            check("irq clear", irq, 32'h0);
            $display("test row %0d done", i);
        end
        // frozen clock enable drops events and holds every output
        apb(1'h1, `ADDR_IRQ_ENABLE, 32'h100);
        @(posedge pclk);
        clk_en <= 1'h0;
        fire(5);
        repeat (3) @(posedge pclk);
        check("frozen irq", irq, 32'h0);
        clk_en <= 1'h1;
        apb(1'h0, `ADDR_IRQ_STATUS, 32'h0);
        check("frozen status", rd, 32'h0);
        $display("test clock enable done");
        // reset in mid-run drops a raised irq and every enable
        apb(1'h1, `ADDR_IRQ_ENABLE, 32'h1);
        apb(1'h1, `ADDR_PORT_CONTROL, 32'h2);
        fire(0);
        repeat (2) @(posedge pclk);
        check("irq before reset", irq, 32'h1);
        presetn <= 1'h0;
        @(posedge pclk);
        check("irq in reset", irq, 32'h0);
        check("auto cts reset", acts, 32'h0);
        presetn <= 1'h1;
        apb(1'h0, `ADDR_IRQ_ENABLE, 32'h0);
        check("enable after reset", rd, 32'h0);
        apb(1'h0, `ADDR_IRQ_STATUS, 32'h0);
        check("status after reset", rd, 32'h0);
        $display("test mid-run reset done");
        results();
    end
endmodule

bind uart_interrupt_enable uart_interrupt_enable_asserts chk_u (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en),
    .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .receive_data_available(receive_data_available),
    .char_timeout(char_timeout), .line_error(line_error),
    .transmit_holding_empty(transmit_holding_empty),
    .clear_to_send_input(clear_to_send_input),
    .modem_change(modem_change), .autobaud_timeout(autobaud_timeout),
    .autobaud_done(autobaud_done), .irq(irq),
    .divisor_latch_access_bit(divisor_latch_access_bit),
    .auto_cts_enable(auto_cts_enable));
`default_nettype wire
